// ### hdl/eepc_pkg.sv
// Overview of operation
// - Power-down bit disables array, reset clears
// - Mode bits pick program/erase; protect blocks
// - Latch bit captures array write address/data
// - Latch clear refused while pump set
// - Clearing both at once clears pump only
// - Auto bit lets timer clear pump
// - Pump runs only with latch and capture
// - Reset loads config from nonvolatile copy
// - Unused bits are plain storage, except control bit 6 and divisor high bits 6:3
// - Security enable is write-once
// - Four protect bits guard 128-byte blocks
// - Security allows byte ops only, top secured
// - Eleven-bit divisor makes 35 us tick
// - Divisor writable when unlatched and unlocked
// - Divider lock freezes divider and its copies
// - Reset copies nonvolatile divider registers
// - Programmed lock bit reloads lock forever
// - Config copy leaves manufacture as F0
// - Wait mode leaves sequence running
// - Stop halts pump, resumes, blocks access while busy
// - Pump set refused without latch and capture
// - Later writes replace capture; reads capture
package eepc_pkg;
  // ---------------------------------------------------------------
  // Address map (word index on the register bus)
  // ---------------------------------------------------------------
  localparam logic [3:0] EEPC_CTRL_IDX = 4'h0;
  localparam logic [3:0] EEPC_ACR_IDX = 4'h1;
  localparam logic [3:0] EEPC_DIVH_IDX = 4'h2;
  localparam logic [3:0] EEPC_DIVL_IDX = 4'h3;
  localparam logic [3:0] EEPC_STAT_IDX = 4'h4;
  localparam logic [3:0] EEPC_NVR_IDX = 4'h8;
  localparam logic [3:0] EEPC_DIVHNV_IDX = 4'h9;
  localparam logic [3:0] EEPC_DIVLNV_IDX = 4'hA;
  // Array window, byte addresses on the bus
  localparam logic [11:0] EEPC_ARR_BASE = 12'h800;
  localparam logic [11:0] EEPC_ARR_LAST = 12'h9FF;
  localparam logic [11:0] EEPC_SEC_BASE = 12'h8F0;
  localparam logic [11:0] EEPC_SEC_LAST = 12'h8FF;
  localparam logic [11:0] EEPC_REG_BASE = 12'h000;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EEPC_PGM_BIT = 0;
  localparam int EEPC_AUTO_BIT = 1;
  localparam int EEPC_LAT_BIT = 2;
  localparam int EEPC_RAS0_BIT = 3;
  localparam int EEPC_RAS1_BIT = 4;
  localparam int EEPC_OFF_BIT = 5;
  localparam int EEPC_SPARE_BIT = 7;
  localparam int EEPC_SECOFF_BIT = 4;
  localparam int EEPC_DSEC_BIT = 7;
  localparam logic [7:0] EEPC_CTRL_WMASK = 8'hBF;
  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] EEPC_NVR_FACTORY = 8'hF0;
  localparam logic [7:0] EEPC_ERASED = 8'hFF;
  localparam int EEPC_CLK_HZ = 10000000;
  localparam int EEPC_TICK_US = 35;
  localparam logic [10:0] EEPC_DIV_DEFAULT =
    11'(EEPC_CLK_HZ / 1000000 * EEPC_TICK_US);
  localparam logic [9:0] EEPC_PGM_TICKS = 10'h0C8;
  localparam logic [9:0] EEPC_ERASE_TICKS = 10'h0C8;
  localparam logic [9:0] EEPC_BLOCK_TICKS = 10'h0C8;
  localparam logic [9:0] EEPC_BULK_TICKS = 10'h0C8;
  // Operation modes
  typedef enum logic [1:0] {
    EEPC_BYTE_PGM, EEPC_BYTE_ERASE, EEPC_BLOCK_ERASE, EEPC_BULK_ERASE
  } eepc_mode_t;
endpackage : eepc_pkg

// ### hdl/eepc_ctrl.sv
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module eepc_ctrl
  import eepc_pkg::*;
(
  input wire logic clock_i, // System clock, 10 MHz
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic [11:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  output logic [1:0] avs_response_o, // 00 ok, 10 slave error
  input wire logic ref_clk_sel_i, // Reference select
  input wire logic ref_tick_i, // Crystal reference pulse
  input wire logic stop_mode_i, // Stop mode pin
  output logic pump_on_o, // High voltage applied
  output logic array_power_down_o, // Array disabled
  output logic busy_o // Sequence in progress
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] ctrl_reg; // Control register
  logic [7:0] acr_reg; // Array configuration, read-only view
  logic [7:0] acr_spare_reg; // Unused configuration bits
  logic [7:0] divh_reg; // Divisor high with lock bit
  logic [7:0] divl_reg; // Divisor low
  logic [7:0] nvr_reg; // Nonvolatile configuration copy
  logic [7:0] divhnv_reg; // Nonvolatile divisor high
  logic [7:0] divlnv_reg; // Nonvolatile divisor low
  logic [7:0] mem [0:511]; // EEPROM array contents
  logic [11:0] cap_addr_reg; // Captured address
  logic [7:0] cap_data_reg; // Captured data
  logic cap_valid_reg; // A valid read or write was captured
  logic [10:0] div_cnt_reg; // Timebase prescaler count
  logic [9:0] tick_cnt_reg; // Elapsed 35 us ticks
  logic done_reg; // Timer finished sequence
  logic load_reg; // Reset load pending
  logic [2:0] stop_sync_reg; // Stop mode synchroniser
  logic stop_reg; // Filtered stop level
  logic [2:0] ref_sync_reg; // Reference synchroniser
  logic ack_reg; // Bus answer strobe
  logic [31:0] rdata_reg; // Read data
  logic [1:0] resp_reg; // Bus response
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // In the array window
  function automatic logic in_array(input logic [11:0] a);
    in_array = (a >= EEPC_ARR_BASE) && (a <= EEPC_ARR_LAST);
  endfunction : in_array
  // Register word index, or all ones when outside register page
  function automatic logic [3:0] reg_idx(input logic [11:0] a);
    reg_idx = (a[11:6] == EEPC_REG_BASE[11:6]) ? a[5:2] : 4'hF;
  endfunction : reg_idx
  // Valid capture target: array or one of the nonvolatile registers
  function automatic logic valid_cap(input logic [11:0] a);
    logic [3:0] i;
    i = reg_idx(a);
    valid_cap = in_array(a) || i == EEPC_NVR_IDX || i == EEPC_DIVHNV_IDX
      || i == EEPC_DIVLNV_IDX;
  endfunction : valid_cap

  logic bus_req; // Fresh request this cycle
  logic [3:0] idx; // Register index
  logic pgm_set; // Pump bit set
  logic lat_set; // Latch bit set
  logic secure; // Array security on
  logic div_lock; // Divider locked
  logic allowed; // Captured operation permitted
  logic [1:0] blk; // Captured block
  logic [8:0] off; // Captured array offset
  logic [9:0] limit; // Tick count for the mode
  eepc_mode_t mode; // Selected mode
  logic [7:0] wb; // Low write byte

  assign bus_req = (avs_read_i || avs_write_i) && !ack_reg;
  assign idx = reg_idx(avs_address_i);
  assign pgm_set = ctrl_reg[EEPC_PGM_BIT];
  assign lat_set = ctrl_reg[EEPC_LAT_BIT];
  assign secure = !acr_reg[EEPC_SECOFF_BIT];
  assign div_lock = !divh_reg[EEPC_DSEC_BIT];
  assign mode = eepc_mode_t'(ctrl_reg[EEPC_RAS1_BIT:EEPC_RAS0_BIT]);
  assign blk = cap_addr_reg[8:7];
  assign off = cap_addr_reg[8:0];
  assign wb = avs_writedata_i[7:0];

  // ---------------------------------------------------------------
  // Protection check
  // ---------------------------------------------------------------
  // Nonvolatile copies skip the array checks: divider copies obey the lock, the config copy security
  always_comb begin
    allowed = 1'b1;
    if (in_array(cap_addr_reg)) begin
      if (acr_reg[blk]) allowed = 1'b0;
      if (secure && (mode == EEPC_BLOCK_ERASE || mode == EEPC_BULK_ERASE))
        allowed = 1'b0;
      if (secure && cap_addr_reg >= EEPC_SEC_BASE && cap_addr_reg <= EEPC_SEC_LAST)
        allowed = 1'b0;
      // Bulk erase clears only when no block is protected
      if (mode == EEPC_BULK_ERASE && acr_reg[3:0] != 4'h0) allowed = 1'b0;
    end else if (reg_idx(cap_addr_reg) != EEPC_NVR_IDX) begin
      if (div_lock) allowed = 1'b0;
    end else begin
      // Erase would set the security bit again, so only programming passes
      if (secure && mode != EEPC_BYTE_PGM) allowed = 1'b0;
    end
  end

  always_comb begin
    unique case (mode)
      EEPC_BYTE_PGM: limit = EEPC_PGM_TICKS;
      EEPC_BYTE_ERASE: limit = EEPC_ERASE_TICKS;
      EEPC_BLOCK_ERASE: limit = EEPC_BLOCK_TICKS;
      EEPC_BULK_ERASE: limit = EEPC_BULK_TICKS;
    endcase
  end

  // ---------------------------------------------------------------
  // Stop mode synchroniser
  // ---------------------------------------------------------------
  // Third stage agreement filters glitches on the pin
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      stop_sync_reg <= 3'h0;
      stop_reg <= 1'b0;
      ref_sync_reg <= 3'h0;
    end else begin
      stop_sync_reg <= {stop_sync_reg[1:0], stop_mode_i};
      ref_sync_reg <= {ref_sync_reg[1:0], ref_tick_i};
      if (stop_sync_reg[1] == stop_sync_reg[2]) stop_reg <= stop_sync_reg[2];
    end
  end

  // ---------------------------------------------------------------
  // Timebase and sequence timer
  // ---------------------------------------------------------------
  // Reference edge: crystal pulse, or every bus clock
  logic ref_en;
  logic [10:0] div_val;
  logic tick;
  assign ref_en = ref_clk_sel_i ? (ref_sync_reg[1] && !ref_sync_reg[2]) : 1'b1;
  assign div_val = {divh_reg[2:0], divl_reg};
  assign tick = ref_en && (div_cnt_reg + 11'h001 >= div_val);
  // Wait mode has no input; stop clears the count, exit restarts it from zero
  always_ff @(posedge clock_i) begin
    if (!rstn_i || !pump_on_o) begin
      div_cnt_reg <= 11'h000;
      tick_cnt_reg <= 10'h000;
      done_reg <= 1'b0;
    end else if (!stop_reg) begin
      if (ref_en) div_cnt_reg <= tick ? 11'h000 : div_cnt_reg + 11'h001;
      if (tick && !done_reg) tick_cnt_reg <= tick_cnt_reg + 10'h001;
      if (tick_cnt_reg >= limit) done_reg <= 1'b1;
    end
  end

  // Voltage removed in stop mode, applied only with latch and capture
  assign pump_on_o = pgm_set && lat_set && cap_valid_reg && allowed && !stop_reg;
  assign busy_o = pgm_set && !done_reg;
  assign array_power_down_o = ctrl_reg[EEPC_OFF_BIT];

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic ctrl_wr;
  logic [7:0] ctrl_next;
  assign ctrl_wr = bus_req && avs_write_i && avs_byteenable_i[0] && idx == EEPC_CTRL_IDX;
  always_comb begin
    ctrl_next = (ctrl_reg & ~EEPC_CTRL_WMASK) | (wb & EEPC_CTRL_WMASK);
    // Pump may not rise without latch and capture
    if (!(lat_set && cap_valid_reg) && !pgm_set)
      ctrl_next[EEPC_PGM_BIT] = 1'b0;
    // Latch held while pump set, also when both cleared together
    if (pgm_set) ctrl_next[EEPC_LAT_BIT] = 1'b1;
  end
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ctrl_reg <= 8'h00;
    end else if (ctrl_wr) begin
      ctrl_reg <= ctrl_next;
    end else if (done_reg && ctrl_reg[EEPC_AUTO_BIT] && pgm_set) begin
      ctrl_reg[EEPC_PGM_BIT] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Capture, array and nonvolatile storage
  // ---------------------------------------------------------------
  logic arr_acc;
  assign arr_acc = bus_req && avs_byteenable_i[0] && lat_set && valid_cap(avs_address_i);
  // Completion edge applies the operation once
  logic commit;
  assign commit = done_reg && pgm_set && !ctrl_wr && ctrl_reg[EEPC_AUTO_BIT] && allowed;
  logic commit_man;
  assign commit_man = done_reg && ctrl_wr && pgm_set && !wb[EEPC_PGM_BIT] && allowed;
  function automatic logic [7:0] apply(input logic [7:0] old);
    apply = (mode == EEPC_BYTE_PGM) ? (old & cap_data_reg) : EEPC_ERASED;
  endfunction : apply
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cap_valid_reg <= 1'b0;
      cap_addr_reg <= 12'h000;
      cap_data_reg <= 8'h00;
    end else if (!lat_set) begin
      cap_valid_reg <= 1'b0;
    end else if (arr_acc && !pgm_set) begin
      cap_addr_reg <= avs_address_i;
      if (avs_write_i) cap_data_reg <= wb;
      cap_valid_reg <= 1'b1;
    end
  end
  always_ff @(posedge clock_i) begin
    if (!nv_init_reg) begin
      // Array leaves manufacture erased
      for (int i = 0; i < 512; i++) begin
        mem[i] <= EEPC_ERASED;
      end
    end else if (commit || commit_man) begin
      if (in_array(cap_addr_reg)) begin
        for (int i = 0; i < 512; i++) begin
          if (i[8:0] == off || mode == EEPC_BULK_ERASE
              || (mode == EEPC_BLOCK_ERASE && i[8:7] == blk))
            mem[i] <= apply(mem[i]);
        end
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      load_reg <= 1'b1;
    end else begin
      load_reg <= 1'b0;
    end
  end
  // Nonvolatile registers survive reset; one-time factory value
  logic nv_init_reg = 1'b0;
  always_ff @(posedge clock_i) begin
    if (!nv_init_reg) begin
      nvr_reg <= EEPC_NVR_FACTORY;
      divhnv_reg <= EEPC_ERASED;
      divlnv_reg <= {EEPC_DIV_DEFAULT[7:0]};
      nv_init_reg <= 1'b1;
    end else if ((commit || commit_man) && !in_array(cap_addr_reg)) begin
      unique case (reg_idx(cap_addr_reg))
        EEPC_NVR_IDX: nvr_reg <= apply(nvr_reg);
        EEPC_DIVHNV_IDX: divhnv_reg <= apply(divhnv_reg);
        default: divlnv_reg <= apply(divlnv_reg);
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Configuration and divider registers
  // ---------------------------------------------------------------
  logic div_wr_ok;
  assign div_wr_ok = bus_req && avs_write_i && avs_byteenable_i[0] && !lat_set
    && !div_lock;
  always_ff @(posedge clock_i) begin
    if (load_reg) begin
      acr_reg <= nvr_reg;
      acr_spare_reg <= nvr_reg;
      divh_reg <= divhnv_reg & 8'h87;
      divl_reg <= divlnv_reg;
    end else begin
      if (bus_req && avs_write_i && avs_byteenable_i[0] && idx == EEPC_ACR_IDX)
        acr_spare_reg <= wb;
      if (div_wr_ok && idx == EEPC_DIVH_IDX) divh_reg <= wb & 8'h87;
      if (div_wr_ok && idx == EEPC_DIVL_IDX) divl_reg <= wb;
    end
  end
  // Security bit reaches the live copy only by the reset reload
  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      resp_reg <= 2'h0;
    end else begin
      ack_reg <= bus_req && !(stop_reg && busy_o);
      resp_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
      if (bus_req && avs_read_i) begin
        if (in_array(avs_address_i))
          rdata_reg[7:0] <= lat_set ? cap_data_reg : mem[avs_address_i[8:0]];
        else unique case (idx)
          EEPC_CTRL_IDX: rdata_reg[7:0] <= ctrl_reg;
          EEPC_ACR_IDX: rdata_reg[7:0] <= {acr_spare_reg[7:5], acr_reg[4:0]};
          EEPC_DIVH_IDX: rdata_reg[7:0] <= divh_reg;
          EEPC_DIVL_IDX: rdata_reg[7:0] <= divl_reg;
          EEPC_STAT_IDX: rdata_reg[7:0] <= {6'h00, done_reg, busy_o};
          EEPC_NVR_IDX: rdata_reg[7:0] <= nvr_reg;
          EEPC_DIVHNV_IDX: rdata_reg[7:0] <= divhnv_reg;
          EEPC_DIVLNV_IDX: rdata_reg[7:0] <= divlnv_reg;
          default: resp_reg <= 2'h2;
        endcase
      end
    end
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
  assign avs_readdata_o = rdata_reg;
  assign avs_response_o = resp_reg;
endmodule : eepc_ctrl

// ### verification/eepc_checker.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Port-level checks of the program/erase block
// ---------------------------------------------
module eepc_checker (
  input wire logic clock_i, // Clock
  input wire logic rstn_i, // Reset, active low
  input wire logic [11:0] avs_address_i, // Address
  input wire logic avs_read_i, // Read
  input wire logic avs_write_i, // Write
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [31:0] avs_readdata_o, // Read data
  input wire logic avs_waitrequest_o, // Stall
  input wire logic stop_mode_i, // Stop pin
  input wire logic pump_on_o, // Pump
  input wire logic array_power_down_o, // Power down
  input wire logic busy_o // Busy
);
  logic ctrl_hit; // Accepted control write
  logic ctrl_take; // Control write taken by the design this cycle
  logic spare_reg; // Last written spare bit
  logic [3:0] calm_reg; // Cycles since stop, saturates
  assign ctrl_hit = avs_write_i && !avs_waitrequest_o && avs_address_i == 12'h000;
  assign ctrl_take = avs_write_i && avs_waitrequest_o && avs_address_i == 12'h000;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  sequence ctrl_rd;
    avs_read_i && !avs_waitrequest_o && avs_address_i == 12'h000;
  endsequence
  // Filter needs a few cycles, so ask for five
  sequence stop_held;
    stop_mode_i [*5];
  endsequence
  // Shadow of the storage-only bit
  always_ff @(posedge clock_i) begin
    if (!rstn_i) spare_reg <= 1'b0;
    else if (ctrl_hit) spare_reg <= avs_writedata_i[7];
  end
  // Resume after stop needs no write
  always_ff @(posedge clock_i) begin
    if (!rstn_i || stop_mode_i) calm_reg <= 4'h0;
    else if (calm_reg != 4'hF) calm_reg <= calm_reg + 4'h1;
  end
  pwr_down_a: assert property (ctrl_hit |=> array_power_down_o == $past(avs_writedata_i[5]))
    else $error("power down bit not taken");
  off_hold_a: assert property (!ctrl_take |=> $stable(array_power_down_o))
    else $error("power down bit moved alone");
  spare_bit_a: assert property (ctrl_rd |-> avs_readdata_o[7:6] == {spare_reg, 1'b0})
    else $error("spare bit lost");
  stop_halt_a: assert property (stop_held |-> !pump_on_o)
    else $error("pump on during stop");
  stall_stop_a: assert property (stop_held ##0 (busy_o && avs_read_i) |-> avs_waitrequest_o)
    else $error("access during halted sequence");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && !busy_o
    |-> ##[0:1] !avs_waitrequest_o)
    else $error("bus answer late");
  pump_busy_a: assert property ($rose(pump_on_o) |-> ##[0:1] busy_o)
    else $error("pump without sequence");
  pump_cause_a: assert property ($rose(pump_on_o)
    |-> $past(ctrl_take && avs_writedata_i[0]) || calm_reg < 4'h8)
    else $error("pump rose without request");
endmodule : eepc_checker
bind eepc_ctrl eepc_checker u_chk (.clock_i(clock_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .stop_mode_i(stop_mode_i), .pump_on_o(pump_on_o),
  .array_power_down_o(array_power_down_o), .busy_o(busy_o));

// ### verification/eepc_cpu_model.sv
`timescale 1ns/1ps
// ---------------------------------
// CPU side: one bus master
// ---------------------------------
module eepc_cpu_model (
  input wire logic clock_i, // Clock
  input wire logic waitreq_i, // Slave stall
  input wire logic [31:0] rdata_i, // Read data
  output logic [11:0] addr_o, // Byte address
  output logic rd_o, // Read strobe
  output logic wr_o, // Write strobe
  output logic [31:0] wdata_o // Write data
);
  initial begin
    addr_o = 12'h000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0;
  end
  // Idle edge first, so strobes never toggle twice
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= {24'h0, d};
    wr_o <= w;
    rd_o <= !w;
    do @(posedge clock_i); while (waitreq_i !== 1'b0);
    q = rdata_i[7:0];
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= ~a; // Released lines show junk
    wdata_o <= {24'hFFFFFF, ~d};
  endtask : xfer
endmodule : eepc_cpu_model

// ### verification/eeprom_program_erase_control_tb.sv
`timescale 1ns/1ps
module eeprom_program_erase_control_tb;
  import eepc_pkg::*;
  logic clock_i, rstn_i, sel, stop, wreq, rd, wr, pon, pdn; // Pins
  logic tick = 1'b0; // Reference pulse
  logic [11:0] addr; // Bus address
  logic [31:0] wdat, rdat; // Bus data
  logic [7:0] q, d, nvr = 8'hF0, acr = 8'hF0; // Reads, config model
  logic [7:0] mem [0:511]; // Array model
  logic [31:0] seed = 32'hE7B145B2; // Random state
  int num_errors = 0, checks = 0; // Tallies
  int opm [12] = '{0, 1, 0, 2, 0, 3, 0, 2, 0, 3, 1, 1}; // Modes
  int opa [12] = '{12'h810, 12'h810, 12'h990, 12'h9A0, 12'h8F8, 12'h800,
    12'h810, 12'h810, 12'h8F8, 12'h810, 12'h810, 12'h818}; // Targets
  eepc_ctrl DUT (.clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'h1), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .avs_response_o(), .ref_clk_sel_i(sel), .ref_tick_i(tick),
    .stop_mode_i(stop), .pump_on_o(pon), .array_power_down_o(pdn), .busy_o());
  eepc_cpu_model cpu (.clock_i(clock_i), .waitreq_i(wreq), .rdata_i(rdat), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdat));
  // ---------------------------------
  // Clock, reference, helpers
  // ---------------------------------
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) tick <= ~tick; // Reference at half rate
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr8(input logic [11:0] a, input logic [7:0] v);
    cpu.xfer(1'b1, a, v, q);
  endtask : wr8
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    cpu.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rchk
  task automatic do_reset();
    rstn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    acr = nvr;
  endtask : do_reset
  // Short divisor keeps each sequence a few hundred cycles
  task automatic set_div();
    wr8(12'h008, 8'h80);
    wr8(12'h00C, 8'h02);
  endtask : set_div
  // Protect or security forbids the operation
  function automatic logic blk(int m, int a);
    if (a < 12'h800) return 1'b0;
    return acr[(a - 12'h800) / 128] | (!acr[4] & (m > 1 | (a >= 12'h8F0 & a <= 12'h8FF)));
  endfunction : blk
  task automatic op(input int m, input int a, input logic [7:0] v, input logic halt);
    logic b;
    b = blk(m, a);
    wr8(12'h000, {3'h0, m[1:0], 3'h6});
    wr8(a[11:0], v);
    wr8(12'h000, {3'h0, m[1:0], 3'h7});
    @(posedge clock_i);
    chk({7'h00, pon}, {7'h00, !b});
    if (halt) begin
      stop <= 1'b1; // Stop mid-sequence on purpose; broken here
      repeat (20) @(posedge clock_i);
      chk({7'h00, pon}, 8'h00);
      stop <= 1'b0;
    end
    if (!b) begin
      do cpu.xfer(1'b0, 12'h000, 8'h00, q); while (q[0] !== 1'b0);
    end
    wr8(12'h000, 8'h00);
    wr8(12'h000, 8'h00);
    rchk(12'h000, 8'h00);
    if (a == 32) nvr = (m == 0) ? (nvr & v) : 8'hFF;
    else if (!b) foreach (mem[j])
      if ((m < 2 && j == a - 2048) || m == 3 || (m == 2 && j / 128 == (a - 2048) / 128))
        mem[j] = (m == 0) ? (mem[j] & v) : 8'hFF;
  endtask : op
  task automatic print_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // ---------------------------------
  // Main sequence and watchdog
  // ---------------------------------
  initial begin
    repeat (80000) @(posedge clock_i);
    num_errors++;
    print_verdict();
  end
  initial begin
    rstn_i = 1'b0;
    sel = 1'b0;
    stop = 1'b0;
    foreach (mem[j]) mem[j] = 8'hFF;
    do_reset();
    rchk(12'h000, 8'h00);
    rchk(12'h004, 8'hF0);
    rchk(12'h008, 8'h87);
    rchk(12'h00C, EEPC_DIV_DEFAULT[7:0]);
    wr8(12'h000, 8'hE0);
    rchk(12'h000, 8'hA0);
    chk({7'h00, pdn}, 8'h01);
    wr8(12'h000, 8'h00);
    d = rnd();
    wr8(12'h00C, d);
    rchk(12'h00C, d);
    set_div();
    wr8(12'h000, 8'h04);
    wr8(12'h00C, 8'h33);
    rchk(12'h00C, 8'h02);
    wr8(12'h700, 8'h00);
    wr8(12'h000, 8'h05);
    rchk(12'h000, 8'h04);
    wr8(12'h820, 8'h00);
    wr8(12'h000, 8'h05);
    wr8(12'h000, 8'h01);
    rchk(12'h000, 8'h05);
    wr8(12'h000, 8'h00);
    rchk(12'h000, 8'h04);
    wr8(12'h000, 8'h00);
    wr8(12'h000, 8'h01);
    rchk(12'h000, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 12; k++) begin
      if (k == 6) begin
        op(1, 32, 8'h00, 1'b0);
        op(0, 32, 8'hEE, 1'b0);
        do_reset();
        set_div();
        rchk(12'h004, 8'hEE);
        sel <= 1'b1;
      end
      op(opm[k], opa[k], rnd(), k == 11);
      rchk(12'h810, mem[16]);
      rchk(12'h8F8, mem[248]);
      rchk(12'h990, mem[400]);
    end
    $display("test array done");
    wr8(12'h008, 8'h00);
    wr8(12'h00C, 8'h55);
    rchk(12'h00C, 8'h02);
    wr8(12'h008, 8'h80);
    rchk(12'h008, 8'h00);
    $display("test lock done");
    print_verdict();
  end
endmodule : eeprom_program_erase_control_tb
